// file: hw/csd_detect.sv
// detection, tuning, noise, shield, bypass, sleep and io logic
//
// Notes on behaviour
// - touch when count drops below baseline by at least selected fraction
// - low touch range codes give 1/32, 1/16, 2/16, 3/16
// - high touch range codes give 4/16, 6/16, 8/16, 10/16
// - one global touch range, per-channel 2-bit code within it
// - proximity when drop below baseline exceeds selected delta
// - proximity deltas 2,3,4,6 low and 8,16,20,30 high; default high code 0
// - one global proximity range switches all channel codes
// - tuning steps compensation upward until channel count reaches target or compensation reaches COMP_MAX
// - tuning request and busy act only after its window closes
// - rf noise shown to the master as a flag
// - noisy samples neither update baseline nor drive detection
// - manual shield may select line pairs 0 to 6, both sides
// - automatic shield pair per group: 0,0,1,2,3
// - proximity pin high while any of channels 0 to 3 reports proximity
// - sleep stops sensing and keeps all settings and data
// - bypass keeps converting without ready until proximity or an spi select is seen
// - bypass clears whenever communication resumes
// - 0, 4 or 8 lines become general purpose pins
// - pin direction changes only during a window
// - pin levels read or written only during a window
// - channels 0-3 proximity only, 4-19 both touch and proximity
// - baseline is a long-term average of each channel's count
`timescale 1ns/1ns
module csd_detect
   import csd_pkg::*;
(
   // clock and reset
   input  wire logic                     clk_in,
   input  wire logic                     reset_in,
   // conversion results
   input  wire logic                     sample_valid_in,
   input  wire logic [CH_W-1:0]          sample_channel_in,
   input  wire logic [COUNT_W-1:0]       sample_count_in,
   input  wire logic [GROUP_W-1:0]       sample_group_in,
   input  wire logic                     cycle_done_in,
   // pins from outside
   input  wire logic                     rf_noise_input_in,
   input  wire logic                     link_clock_in,
   input  wire logic                     link_select_n_in,
   input  wire logic                     spi_mode_strap_in,
   input  wire logic [GPIO_W-1:0]        gpio_pin_in,
   // settings
   input  wire logic                     touch_range_high_in,
   input  wire logic                     prox_range_low_in,
   input  wire logic [NUM_CH*CODE_W-1:0] touch_code_in,
   input  wire logic [NUM_CH*CODE_W-1:0] prox_code_in,
   input  wire logic                     sleep_in,
   input  wire logic                     bypass_cmd_in,
   input  wire logic                     tune_request_in,
   input  wire logic                     tune_touch_group_in,
   input  wire logic [COUNT_W-1:0]       tune_target_in,
   input  wire logic                     shield_auto_in,
   input  wire logic [SHIELD_W-1:0]      shield_manual_a_in,
   input  wire logic [SHIELD_W-1:0]      shield_manual_b_in,
   input  wire logic [1:0]               gpio_count_sel_in,
   input  wire logic                     dir_write_in,
   input  wire logic [GPIO_W-1:0]        dir_data_in,
   input  wire logic                     level_write_in,
   input  wire logic [GPIO_W-1:0]        level_data_in,
   // results and status
   output logic                          ready_out,
   output logic [NUM_CH-1:0]             touch_status_out,
   output logic [NUM_CH-1:0]             prox_status_out,
   output logic                          proximity_output_pin_out,
   output logic                          rf_noise_flag_out,
   output logic                          tune_busy_out,
   output logic [NUM_CH*COMP_W-1:0]      compensation_out,
   output logic                          sensing_enable_out,
   output logic                          bypass_active_out,
   output logic                          spi_mode_out,
   // lines and pins
   output logic [SHIELD_W-1:0]           shield_output_a_out,
   output logic [SHIELD_W-1:0]           shield_output_b_out,
   output logic [LINE_W-1:0]             sense_line_enable_out,
   output logic [GPIO_W-1:0]             gpio_out,
   output logic [GPIO_W-1:0]             gpio_oe_out,
   output logic [GPIO_W-1:0]             gpio_level_out
);
   function automatic logic [GPIO_W-1:0] io_mask(input logic [1:0] sel);
      io_mask = (sel == GPIO_SEL_EIGHT) ? GPIO_MASK_ALL :
                (sel == GPIO_SEL_FOUR)  ? GPIO_MASK_FOUR : '0;
   endfunction : io_mask

   logic [2:0]               rf_sync_reg, sck_sync_reg, sel_sync_reg;
   logic [1:0]               strap_sync_reg;
   logic [GPIO_W-1:0]        gpio_s1_reg, gpio_s2_reg;
   logic                     strap_taken_reg;
   logic [COUNT_W-1:0]       baseline_reg [NUM_CH];
   logic [NUM_CH-1:0]        seeded_reg, tune_done_reg;
   logic [NUM_CH-1:0][COMP_W-1:0] comp_reg;
   logic [NUM_CH-1:0]        prox_next, touch_next;
   logic                     link_active_reg, bypass_reg, resume_reg, tune_pend_reg;
   logic                     tune_group_reg, tune_req_grp_reg;
   logic [COUNT_W-1:0]       tune_target_reg;
   logic [GPIO_W-1:0]        dir_reg, level_reg;
   logic                     noisy, accept, ch_ok, window_close, window_open;
   logic                     sck_rise, sel_fall, sel_rise, touch_hit, prox_hit;
   logic [COUNT_W-1:0]       base_now;
   logic signed [COUNT_W:0]  diff;
   logic [NUM_CH-1:0]        tune_mask;
   logic [SHIELD_W-1:0]      shield_a, shield_b;
   logic [GPIO_W-1:0]        pin_mask;
   logic [LINE_W-1:0]        line_off;

   csd_thresh u_thresh (
      .count_in      (sample_count_in),
      .baseline_in   (base_now),
      .touch_code_in (touch_code_in[sample_channel_in*CODE_W +: CODE_W]),
      .prox_code_in  (prox_code_in[sample_channel_in*CODE_W +: CODE_W]),
      .touch_high_in (touch_range_high_in),
      .prox_high_in  (!prox_range_low_in),
      .touch_hit_out (touch_hit),
      .prox_hit_out  (prox_hit)
   );

   csd_shield u_shield (
      .auto_in     (shield_auto_in),
      .manual_a_in (shield_manual_a_in),
      .manual_b_in (shield_manual_b_in),
      .group_in    (sample_group_in),
      .sel_a_out   (shield_a),
      .sel_b_out   (shield_b)
   );

   // pin synchronisers; stage 0 feeds only stage 1
   always_ff @(posedge clk_in) begin
      rf_sync_reg    <= {rf_sync_reg[1:0], rf_noise_input_in};
      sck_sync_reg   <= {sck_sync_reg[1:0], link_clock_in};
      sel_sync_reg   <= {sel_sync_reg[1:0], link_select_n_in};
      strap_sync_reg <= {strap_sync_reg[0], spi_mode_strap_in};
      gpio_s1_reg    <= gpio_pin_in;
      gpio_s2_reg    <= gpio_s1_reg;
   end

   always_comb begin
      sck_rise = sck_sync_reg[1] && !sck_sync_reg[2];
      sel_fall = !sel_sync_reg[1] && sel_sync_reg[2];
      sel_rise = sel_sync_reg[1] && !sel_sync_reg[2];
      window_close = ready_out && link_active_reg && sel_rise;
      // no window while bypassed unless resuming
      window_open  = !ready_out && cycle_done_in && !sleep_in && (!bypass_reg || resume_reg);
      noisy    = rf_sync_reg[1];
      ch_ok    = sample_channel_in < CH_W'(NUM_CH);
      accept   = sample_valid_in && ch_ok && !noisy && !sleep_in;
      base_now = ch_ok ? baseline_reg[sample_channel_in] : '0;
      diff     = $signed({1'b0, sample_count_in}) - $signed({1'b0, base_now});
      tune_mask = tune_group_reg ? TOUCH_GROUP_MASK : PROX_GROUP_MASK;
      prox_next  = prox_status_out;
      touch_next = touch_status_out;
      if (accept) begin
         prox_next[sample_channel_in] = seeded_reg[sample_channel_in] && prox_hit;
         // touch only on channels 4 to 19
         touch_next[sample_channel_in] = seeded_reg[sample_channel_in] && touch_hit &&
                                         (sample_channel_in >= CH_W'(NUM_PROX_CH));
      end
   end

   // strap caught once after reset release
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         strap_taken_reg <= 1'b0;
         spi_mode_out    <= 1'b0;
      end else if (!strap_taken_reg) begin
         strap_taken_reg <= 1'b1;
         spi_mode_out    <= strap_sync_reg[1];
      end
   end

   // communication window on the ready line
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ready_out       <= 1'b0;
         link_active_reg <= 1'b0;
      end else begin
         if (window_close) begin
            ready_out <= 1'b0;
         end else if (window_open) begin
            ready_out <= 1'b1;
         end
         // window ends only after the master actually clocked
         if (!ready_out) begin
            link_active_reg <= 1'b0;
         end else if (sck_rise && !sel_sync_reg[1]) begin
            link_active_reg <= 1'b1;
         end
      end
   end

   // bypass and resume
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         bypass_reg <= 1'b0;
         resume_reg <= 1'b0;
      end else if (window_open) begin
         bypass_reg <= 1'b0;
         resume_reg <= 1'b0;
      end else begin
         if (bypass_cmd_in && ready_out) begin
            bypass_reg <= 1'b1;
         end
         // proximity or spi select ends bypass
         // a select inside an open window is plain traffic
         if (bypass_reg && (|prox_status_out || (spi_mode_out && sel_fall && !ready_out))) begin
            resume_reg <= 1'b1;
         end
      end
   end
   assign bypass_active_out = bypass_reg;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         seeded_reg <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            baseline_reg[i] <= '0;
         end
      end else if (accept) begin
         seeded_reg[sample_channel_in] <= 1'b1;
         if (!seeded_reg[sample_channel_in]) begin
            baseline_reg[sample_channel_in] <= sample_count_in;
         end else begin
            baseline_reg[sample_channel_in] <= base_now +
               COUNT_W'(diff >>> BASELINE_SHIFT);
         end
      end
   end

   // status, proximity pin and noise flag
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         prox_status_out          <= '0;
         touch_status_out         <= '0;
         proximity_output_pin_out <= 1'b0;
         rf_noise_flag_out        <= 1'b0;
      end else begin
         prox_status_out          <= prox_next;
         touch_status_out         <= touch_next;
         proximity_output_pin_out <= |prox_next[NUM_PROX_CH-1:0];
         // noise seen, set wins over the window clear
         if (sample_valid_in && noisy) begin
            rf_noise_flag_out <= 1'b1;
         end else if (window_close) begin
            rf_noise_flag_out <= 1'b0;
         end
      end
   end

   // automatic tuning
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         tune_pend_reg    <= 1'b0;
         tune_busy_out    <= 1'b0;
         tune_group_reg   <= 1'b0;
         tune_req_grp_reg <= 1'b0;
         tune_target_reg  <= '0;
         tune_done_reg    <= '0;
         comp_reg         <= '0;
      end else begin
         if (tune_request_in && ready_out) begin
            tune_pend_reg    <= 1'b1;
            tune_req_grp_reg <= tune_touch_group_in;
            tune_target_reg  <= tune_target_in;
         end
         // starts only once the window has closed
         if (window_close && (tune_pend_reg || tune_request_in)) begin
            tune_pend_reg  <= 1'b0;
            tune_busy_out  <= 1'b1;
            tune_group_reg <= tune_request_in ? tune_touch_group_in : tune_req_grp_reg;
            tune_done_reg  <= '0;
         end else if (tune_busy_out) begin
            if ((tune_done_reg & tune_mask) == tune_mask) begin
               tune_busy_out <= 1'b0;
            end else if (accept && tune_mask[sample_channel_in]) begin
               if (sample_count_in < tune_target_reg &&
                   comp_reg[sample_channel_in] != COMP_MAX) begin
                  comp_reg[sample_channel_in] <= comp_reg[sample_channel_in] + 1'b1;
               end else begin
                  tune_done_reg[sample_channel_in] <= 1'b1;
               end
            end
         end
      end
   end
   assign compensation_out = comp_reg;

   // shield drive, registered
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         shield_output_a_out <= '0;
         shield_output_b_out <= '0;
         sensing_enable_out  <= 1'b0;
      end else begin
         // manual mask passes through when not automatic
         shield_output_a_out <= shield_a;
         shield_output_b_out <= shield_b;
         sensing_enable_out  <= !sleep_in;
      end
   end

   // general purpose pins
   always_comb begin
      pin_mask = io_mask(gpio_count_sel_in);
      line_off = '0;
      for (int i = 0; i < GPIO_W / 2; i++) begin
         line_off[GPIO_LINE_A + i]  = pin_mask[i];
         line_off[GPIO_LINE_B + GPIO_LINE_A + i] = pin_mask[GPIO_W / 2 + i];
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         dir_reg               <= '0;
         level_reg             <= '0;
         gpio_out              <= '0;
         gpio_oe_out           <= '0;
         gpio_level_out        <= '0;
         sense_line_enable_out <= '0;
      end else begin
         if (dir_write_in && ready_out) begin
            dir_reg <= dir_data_in;
         end
         if (level_write_in && ready_out) begin
            level_reg <= level_data_in;
         end
         if (ready_out) begin
            gpio_level_out <= gpio_s2_reg & pin_mask;
         end
         // io lines leave the sensing set
         sense_line_enable_out <= ~line_off;
         gpio_oe_out           <= dir_reg & pin_mask;
         gpio_out              <= level_reg & pin_mask;
      end
   end

   property p_pin;
      @(posedge clk_in) disable iff (reset_in)
      proximity_output_pin_out == |prox_status_out[NUM_PROX_CH-1:0];
   endproperty
   a_pin: assert property (p_pin) else $error("proximity pin mismatch");

   property p_noise;
      @(posedge clk_in) disable iff (reset_in)
      sample_valid_in && noisy |=> $stable(prox_status_out) && $stable(touch_status_out)
                                   && rf_noise_flag_out;
   endproperty
   a_noise: assert property (p_noise) else $error("noisy sample changed status");

   property p_sleep;
      @(posedge clk_in) disable iff (reset_in)
      sleep_in |=> $stable(prox_status_out) && !sensing_enable_out;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sensing while asleep");

   property p_tune;
      @(posedge clk_in) disable iff (reset_in)
      $rose(tune_busy_out) |-> $past(window_close);
   endproperty
   a_tune: assert property (p_tune) else $error("tuning began inside a window");

   property p_bypass;
      @(posedge clk_in) disable iff (reset_in)
      $rose(ready_out) |-> $past(!bypass_reg || resume_reg) && !bypass_active_out;
   endproperty
   a_bypass: assert property (p_bypass) else $error("ready raised during bypass");

   property p_dir;
      @(posedge clk_in) disable iff (reset_in)
      !ready_out |=> $stable(dir_reg) && $stable(level_reg);
   endproperty
   a_dir: assert property (p_dir) else $error("pin setting changed outside window");

   property p_touch_split;
      @(posedge clk_in) disable iff (reset_in)
      touch_status_out[NUM_PROX_CH-1:0] == '0;
   endproperty
   a_touch_split: assert property (p_touch_split) else $error("touch on proximity channel");

   property p_shield;
      @(posedge clk_in) disable iff (reset_in)
      shield_auto_in && sample_group_in == LAST_GROUP |=> shield_output_a_out == 7'h08;
   endproperty
   a_shield: assert property (p_shield) else $error("auto shield pair wrong");
endmodule : csd_detect

// file: hw/csd_pkg.sv
// shared constants for the capacitive detection and auxiliary logic
package csd_pkg;
   localparam int NUM_CH      = 20;
   localparam int NUM_PROX_CH = 4;
   localparam int CH_W        = 5;
   localparam int COUNT_W     = 16;
   localparam int COMP_W      = 6;
   localparam int LINE_W      = 16;
   localparam int GPIO_W      = 8;
   localparam int SHIELD_W    = 7;
   localparam int GROUP_W     = 3;
   localparam int CODE_W      = 2;
   localparam int NUM_W       = 5;

   // touch fraction numerators over 32, code 3 down to code 0
   // low and high range fractions
   localparam logic [19:0] TOUCH_NUM_LO = {5'h06, 5'h04, 5'h02, 5'h01};
   localparam logic [19:0] TOUCH_NUM_HI = {5'h14, 5'h10, 5'h0C, 5'h08};
   localparam int          TOUCH_SHIFT  = 5;
   // proximity deltas in counts, code 3 down to code 0
   // low and high deltas
   localparam logic [19:0] PROX_DELTA_LO = {5'h06, 5'h04, 5'h03, 5'h02};
   localparam logic [19:0] PROX_DELTA_HI = {5'h1E, 5'h14, 5'h10, 5'h08};

   localparam int             BASELINE_SHIFT = 4;
   localparam logic [COMP_W-1:0] COMP_MAX    = 6'h3F;

   // shield pair per charge group, group 4 down to group 0
   localparam logic [14:0] SHIELD_PAIR_TBL = {3'h3, 3'h2, 3'h1, 3'h0, 3'h0};
   localparam logic [GROUP_W-1:0] LAST_GROUP = 3'h4;

   localparam logic [1:0]        GPIO_SEL_FOUR  = 2'h1;
   localparam logic [1:0]        GPIO_SEL_EIGHT = 2'h2;
   localparam logic [GPIO_W-1:0] GPIO_MASK_FOUR = 8'h33;
   localparam logic [GPIO_W-1:0] GPIO_MASK_ALL  = 8'hFF;
   localparam int                GPIO_LINE_A    = 4;
   localparam int                GPIO_LINE_B    = 8;
   localparam logic [NUM_CH-1:0] PROX_GROUP_MASK  = 20'h0000F;
   localparam logic [NUM_CH-1:0] TOUCH_GROUP_MASK = 20'hFFFF0;
endpackage : csd_pkg

// file: hw/csd_thresh.sv
// compares one count against its baseline with touch and proximity codes
`timescale 1ns/1ns
module csd_thresh
   import csd_pkg::*;
(
   // sample and reference
   input  wire logic [COUNT_W-1:0] count_in,
   input  wire logic [COUNT_W-1:0] baseline_in,
   // settings
   input  wire logic [CODE_W-1:0]  touch_code_in,
   input  wire logic [CODE_W-1:0]  prox_code_in,
   input  wire logic               touch_high_in,
   input  wire logic               prox_high_in,
   // decisions
   output logic                    touch_hit_out,
   output logic                    prox_hit_out
);
   logic [COUNT_W-1:0]         drop;
   logic [NUM_W-1:0]           num;
   logic [NUM_W-1:0]           delta;
   logic [COUNT_W+NUM_W-1:0]   product;
   logic [COUNT_W-1:0]         touch_thr;

   always_comb begin
      // a touch lowers the count, so only a drop counts
      drop      = (count_in < baseline_in) ? baseline_in - count_in : '0;
      num       = touch_high_in ? TOUCH_NUM_HI[touch_code_in*NUM_W +: NUM_W]
                                : TOUCH_NUM_LO[touch_code_in*NUM_W +: NUM_W];
      delta     = prox_high_in ? PROX_DELTA_HI[prox_code_in*NUM_W +: NUM_W]
                               : PROX_DELTA_LO[prox_code_in*NUM_W +: NUM_W];
      product   = baseline_in * num;
      touch_thr = product[TOUCH_SHIFT +: COUNT_W];
      touch_hit_out = (drop >= touch_thr) && (drop != '0);
      prox_hit_out  = drop > COUNT_W'(delta);
   end
endmodule : csd_thresh

// file: hw/csd_shield.sv
// picks shielded line pairs, manual mask or automatic per group
`timescale 1ns/1ns
module csd_shield
   import csd_pkg::*;
(
   // control
   input  wire logic                auto_in,
   input  wire logic [SHIELD_W-1:0] manual_a_in,
   input  wire logic [SHIELD_W-1:0] manual_b_in,
   input  wire logic [GROUP_W-1:0]  group_in,
   // selection
   output logic      [SHIELD_W-1:0] sel_a_out,
   output logic      [SHIELD_W-1:0] sel_b_out
);
   logic [GROUP_W-1:0] pair;

   always_comb begin
      pair      = SHIELD_PAIR_TBL[group_in*GROUP_W +: GROUP_W];
      sel_a_out = manual_a_in;
      sel_b_out = manual_b_in;
      if (auto_in) begin
         sel_a_out = '0;
         if (group_in <= LAST_GROUP) begin
            sel_a_out[pair] = 1'b1;
         end
         sel_b_out = sel_a_out;
      end
   end
endmodule : csd_shield

// file: bench/csd_host.sv
// host master model driving the serial select and clock pins
`timescale 1ns/1ns
module csd_host (
   // clock
   input  wire logic clk_in,
   // serial pins
   output logic      link_clock_out,
   output logic      link_select_n_out
);
   initial begin
      link_clock_out = 1'b1;
      link_select_n_out = 1'b1;
   end
   task automatic select_low;
      @(negedge clk_in);
      link_select_n_out = 1'b0;
   endtask : select_low
   // clock idles high, runs only in a frame
   task automatic close_window;
      select_low();
      repeat (2) begin
         repeat (4) @(negedge clk_in);
         link_clock_out = 1'b0;
         repeat (4) @(negedge clk_in);
         link_clock_out = 1'b1;
      end
      repeat (4) @(negedge clk_in);
      link_select_n_out = 1'b1;
   endtask : close_window
endmodule : csd_host

// file: bench/csd_detect_tb.sv
// self-checking bench for the detection and auxiliary logic
`timescale 1ns/1ns
module csd_detect_tb import csd_pkg::*; ;
   logic clk_in = 1'b0, reset_in = 1'b1, sv = 1'b0, cd = 1'b0, rf = 1'b0, thi = 1'b0;
   logic plo = 1'b0, byp = 1'b0, tune = 1'b0, sha_auto = 1'b0, dwr = 1'b0, slp = 1'b0;
   logic [1:0] gsel = 2'h2;
   logic [CH_W-1:0] sch = 5'h00;
   logic [COUNT_W-1:0] scnt = 16'h0000;
   logic [GROUP_W-1:0] grp = 3'h0;
   logic [NUM_CH*CODE_W-1:0] tc, pc;
   logic [SHIELD_W-1:0] man = 7'h55;
   logic [GPIO_W-1:0] dd = 8'hFF;
   wire lclk, lsel_n, rdy, pin, nflag, busy, bact, sen, smode;
   wire [NUM_CH-1:0] tst, pst;
   wire [SHIELD_W-1:0] sha, shb;
   wire [GPIO_W-1:0] oe, gout, glv;
   wire [LINE_W-1:0] sle;
   wire [NUM_CH*COMP_W-1:0] comp;
   int err_total = 0, checks_done = 0;
   int thr [2][4] = '{'{32, 64, 128, 192}, '{256, 384, 512, 640}};
   int dlt [2][4] = '{'{2, 3, 4, 6}, '{8, 16, 20, 30}};
   always #5 clk_in = ~clk_in;
   csd_host host (.clk_in(clk_in), .link_clock_out(lclk), .link_select_n_out(lsel_n));
   csd_detect dut (.clk_in(clk_in), .reset_in(reset_in), .sample_valid_in(sv),
      .sample_channel_in(sch), .sample_count_in(scnt), .sample_group_in(grp),
      .cycle_done_in(cd), .rf_noise_input_in(rf), .link_clock_in(lclk),
      .link_select_n_in(lsel_n), .spi_mode_strap_in(1'b1), .gpio_pin_in(dd),
      .touch_range_high_in(thi), .prox_range_low_in(plo), .touch_code_in(tc),
      .prox_code_in(pc), .sleep_in(slp), .bypass_cmd_in(byp), .tune_request_in(tune),
      .tune_touch_group_in(1'b0), .tune_target_in(16'h0800), .shield_auto_in(sha_auto),
      .shield_manual_a_in(man), .shield_manual_b_in(man), .gpio_count_sel_in(gsel),
      .dir_write_in(dwr), .dir_data_in(dd), .level_write_in(dwr), .level_data_in(dd),
      .ready_out(rdy), .touch_status_out(tst), .prox_status_out(pst),
      .proximity_output_pin_out(pin), .rf_noise_flag_out(nflag), .tune_busy_out(busy),
      .compensation_out(comp), .sensing_enable_out(sen), .bypass_active_out(bact),
      .spi_mode_out(smode), .shield_output_a_out(sha), .shield_output_b_out(shb),
      .sense_line_enable_out(sle), .gpio_out(gout), .gpio_oe_out(oe), .gpio_level_out(glv));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : check
   task automatic wait_rdy(input logic v);
      int n;
      n = 0;
      while (rdy !== v && n < 300) begin
         @(negedge clk_in);
         n++;
      end
      if (rdy !== v) begin
         err_total++;
         stop_test();
      end
   endtask : wait_rdy
   task automatic do_reset;
      {thi, plo, tc, pc} = '0;
      reset_in = 1'b1;
      repeat (20) @(negedge clk_in);
      reset_in = 1'b0;
      @(negedge clk_in);
   endtask : do_reset
   task automatic sample(input int ch, input int cnt);
      sch = CH_W'(ch);
      scnt = COUNT_W'(cnt);
      sv = 1'b1;
      @(negedge clk_in);
      sv = 1'b0;
      repeat (2) @(negedge clk_in);
   endtask : sample
   task automatic cyc;
      cd = 1'b1;
      @(negedge clk_in);
      cd = 1'b0;
   endtask : cyc
   // one channel seeded at 1024, then dropped
   task automatic thr_case(input int ch, input logic hi, input logic [1:0] code,
                           input int drop, input logic exp);
      do_reset();
      thi = hi;
      plo = ~hi;
      tc[2*ch +: 2] = code;
      pc[2*ch +: 2] = code;
      sample(ch, 1024);
      sample(ch, 1024 - drop);
      if (ch < NUM_PROX_CH) begin
         check(pst[ch], exp);
         check(pin, exp);
         check(tst[ch], 1'b0);
      end else check(tst[ch], exp);
   endtask : thr_case
   // noisy sample must leave baseline alone
   task automatic noise_case;
      do_reset();
      sample(0, 1024);
      rf = 1'b1;
      repeat (3) @(negedge clk_in);
      sample(0, 0);
      check(pst[0], 1'b0);
      check(nflag, 1'b1);
      rf = 1'b0;
      repeat (3) @(negedge clk_in);
      sample(0, 1015);
      check(pst[0], 1'b1);
      sample(0, 512);
      check(tst[0], 1'b0);
   endtask : noise_case
   // sleep freezes sensing and keeps the baseline
   task automatic sleep_case;
      do_reset();
      sample(0, 1024);
      slp = 1'b1;
      sample(0, 0);
      cyc();
      check(pst[0], 1'b0);
      check(sen, 1'b0);
      check(rdy, 1'b0);
      slp = 1'b0;
      sample(0, 1015);
      check(pst[0], 1'b1);
      check(sen, 1'b1);
   endtask : sleep_case
   task automatic window_case;
      do_reset();
      dwr = 1'b1;
      @(negedge clk_in);
      dwr = 1'b0;
      repeat (2) @(negedge clk_in);
      check(oe, 8'h00);
      check(gout, 8'h00);
      check(glv, 8'h00);
      cyc();
      wait_rdy(1'b1);
      {dwr, tune, byp} = 3'h7;
      @(negedge clk_in);
      {dwr, tune, byp} = 3'h0;
      repeat (2) @(negedge clk_in);
      check(oe, 8'hFF);
      check(gout, 8'hFF);
      check(glv, 8'hFF);
      check(smode, 1'b1);
      check(busy, 1'b0);
      host.close_window();
      wait_rdy(1'b0);
      @(negedge clk_in);
      check(busy, 1'b1);
      check(bact, 1'b1);
      sample(0, 256);
      check(comp[5:0], 6'h01);
      cyc();
      repeat (5) @(negedge clk_in);
      check(rdy, 1'b0);
      host.select_low();
      repeat (4) @(negedge clk_in);
      cyc();
      wait_rdy(1'b1);
      check(bact, 1'b0);
      host.close_window();
      wait_rdy(1'b0);
   endtask : window_case
   task automatic shield_case;
      int pair [5] = '{0, 0, 1, 2, 3};
      logic [15:0] sle_exp [3] = '{16'hFFFF, 16'hCFCF, 16'h0F0F};
      logic [7:0] oe_exp [3] = '{8'h00, 8'h33, 8'hFF};
      sha_auto = 1'b1;
      for (int g = 0; g < 5; g++) begin
         grp = GROUP_W'(g);
         repeat (2) @(negedge clk_in);
         check(sha, 7'h01 << pair[g]);
         check(shb, 7'h01 << pair[g]);
      end
      sha_auto = 1'b0;
      repeat (2) @(negedge clk_in);
      check(sha, 7'h55);
      check(shb, 7'h55);
      for (int s = 0; s < 3; s++) begin
         gsel = 2'(s);
         repeat (2) @(negedge clk_in);
         check(sle, sle_exp[s]);
         check(oe, oe_exp[s]);
      end
   endtask : shield_case
   initial begin
      {tc, pc} = '0;
      for (int r = 0; r < 2; r++) begin
         for (int c = 0; c < 4; c++) begin
            thr_case(4 + c, r[0], c[1:0], thr[r][c], 1'b1);
            thr_case(8 + c, r[0], c[1:0], thr[r][c] - 1, 1'b0);
            thr_case(c, r[0], c[1:0], dlt[r][c] + 1, 1'b1);
            thr_case(c, r[0], c[1:0], dlt[r][c], 1'b0);
         end
      end
      noise_case();
      sleep_case();
      window_case();
      shield_case();
      stop_test();
   end
endmodule : csd_detect_tb
